// file: rtl/acm_device.sv
// converter end: conversion modes, chop sequencing, standby and current detect
// Summary of operation
// - continuous mode: result every oversampling ratio periods
// - chop mode averages opposite-polarity conversion pairs
// - filter reset on every polarity swap
// - settling delay after swap from field code
// - chop period is delay plus three ratios
// - end of short sync pulse or ratio change restarts chop
// - first chop result adds 44 extra periods
// - chop mode bypasses phase calibration
// - dc test signal unavailable in chop mode
// - two-bit power level select, both modes
// - standby command disables channels, keeps registers
// - resume command: sampling after 8 periods
// - short sync pulse enters detect from standby
// - detect compares magnitudes, notifies, returns standby
// - detect runs on internal timer, hides results
// - host stops external clock during detect
// - detect enable bit and 24-bit split threshold
// - sample length field sets pass length
// - exceed count field sets needed exceedances
// - all-channels bit chooses every or any channel
// - data ready active low for data or detection
// - long sync low resets until pin high
`include "acm_cfg.svh"
module acm_device #(parameter int CD_PERIOD_CYC = `ACM_CD_PERIOD_CYC)
(
	input  wire logic        MCLK_I,
	input  wire logic        SYS_RST_I,
	acm_if.dev               LINK,
	input  wire logic [95:0] SAMPLE_I,
	output logic      [95:0] CONV_DATA_O,
	output logic             CONV_VALID_O,
	output logic             POLARITY_O,
	output logic             FILTER_RST_O,
	output logic             PHASE_BYPASS_O,
	output logic             DC_TEST_OK_O,
	output logic      [1:0]  POWER_LEVEL_O,
	output logic      [3:0]  CHAN_ACTIVE_O,
	output logic             REF_PD_O,
	output logic      [2:0]  MODE_O
);
	acm_pkg::acm_state_t state_reg;
	logic [15:0] clock_reg, gchop_reg, cfg_reg, thr_up_reg, thr_lo_reg;
	logic [15:0] low_cnt_reg;
	logic        sync_d_reg;
	logic [7:0]  div_cnt_reg;
	logic [31:0] cd_cnt_reg;
	logic [17:0] tcnt_reg;
	logic [1:0]  gc_left_reg;
	logic        first_reg, pol_reg, frst_reg, valid_reg;
	logic [3:0]  data_ready_n_cnt_reg;
	logic [11:0] cd_samp_reg;
	logic [95:0] prev_reg, data_reg;
	logic [17:0] osr_len, dly_len, seg_len;
	logic [11:0] detect_sample_length;
	logic [7:0]  detect_exceed_count;
	logic [3:0]  ch_en, hit;
	logic        chop, wr, mod_tick, cd_tick, long_low, short_pulse, restart, seg_end;
	logic        cmd_stby, cmd_wake, osr_change, met, pass_end;

	acm_lut i_acm_lut
	(
		.OSR_CODE_I (clock_reg[`ACM_F_OSR_HI:`ACM_F_OSR_LO]),
		.DLY_CODE_I (gchop_reg[`ACM_F_CHOP_SETTLE_DELAY_HI:`ACM_F_CHOP_SETTLE_DELAY_LO]),
		.LEN_CODE_I (cfg_reg[`ACM_F_DETECT_SAMPLE_LENGTH_HI:`ACM_F_DETECT_SAMPLE_LENGTH_LO]),
		.NUM_CODE_I (cfg_reg[`ACM_F_DETECT_EXCEED_COUNT_HI:`ACM_F_DETECT_EXCEED_COUNT_LO]),
		.OSR_LEN_O  (osr_len),
		.DLY_LEN_O  (dly_len),
		.DETECT_SAMPLE_LENGTH_O   (detect_sample_length),
		.DETECT_EXCEED_COUNT_O   (detect_exceed_count)
	);

	// command decode and field views
	assign chop       = gchop_reg[`ACM_F_CHOP_ENABLE];
	assign ch_en      = clock_reg[`ACM_F_CHEN_HI:`ACM_F_CHEN_LO];
	assign wr         = LINK.cmd_valid && (LINK.cmd_op == `ACM_OP_WREG);
	assign cmd_stby   = LINK.cmd_valid && (LINK.cmd_op == `ACM_OP_STANDBY);
	assign cmd_wake   = LINK.cmd_valid && (LINK.cmd_op == `ACM_OP_WAKE);
	assign osr_change = wr && (LINK.cmd_addr == `ACM_RA_CLOCK) &&
		(LINK.cmd_data[`ACM_F_OSR_HI:`ACM_F_OSR_LO] != clock_reg[`ACM_F_OSR_HI:`ACM_F_OSR_LO]);

	// register file; pin reset restores defaults, standby keeps them
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || state_reg == acm_pkg::ST_RESET)
		begin
			clock_reg  <= `ACM_CLOCK_RST;
			gchop_reg  <= `ACM_GCHOP_RST;
			cfg_reg    <= `ACM_CFG_RST;
			thr_up_reg <= `ACM_THR_RST;
			thr_lo_reg <= `ACM_THR_RST;
		end
		else if (wr)
		begin
			unique case (LINK.cmd_addr)
				`ACM_RA_CLOCK:  clock_reg  <= LINK.cmd_data;
				`ACM_RA_GCHOP:  gchop_reg  <= LINK.cmd_data;
				`ACM_RA_CFG:    cfg_reg    <= LINK.cmd_data;
				`ACM_RA_THR_UP: thr_up_reg <= LINK.cmd_data;
				`ACM_RA_THR_LO: thr_lo_reg <= LINK.cmd_data;
				default:        ;
			endcase
		end
	end

	// sync pin low-time measurement
	assign long_low    = !LINK.sync_n && (low_cnt_reg >= `ACM_RSL_CYC - 16'h0001);
	assign short_pulse = LINK.sync_n && !sync_d_reg && (low_cnt_reg < `ACM_RSL_CYC);
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
		begin
			sync_d_reg  <= 1'b1;
			low_cnt_reg <= 16'h0000;
		end
		else
		begin
			sync_d_reg <= LINK.sync_n;
			if (LINK.sync_n)
				low_cnt_reg <= 16'h0000;
			else if (low_cnt_reg != `ACM_RSL_CYC)
				low_cnt_reg <= low_cnt_reg + 16'h0001;
		end
	end

	// modulator tick only while the external clock runs; detect tick from internal timer
	assign mod_tick = LINK.external_clock_input_run && (div_cnt_reg == `ACM_MOD_DIV - 8'h01);
	assign cd_tick  = (cd_cnt_reg == 32'(CD_PERIOD_CYC - 1));
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || !LINK.external_clock_input_run || mod_tick)
			div_cnt_reg <= 8'h00;
		else
			div_cnt_reg <= div_cnt_reg + 8'h01;
	end
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || state_reg != acm_pkg::ST_DETECT || cd_tick)
			cd_cnt_reg <= 32'h00000000;
		else
			cd_cnt_reg <= cd_cnt_reg + 32'h00000001;
	end

	// detection outcome over enabled channels
	assign met = cfg_reg[`ACM_F_DETECT_ALL_CHANNELS] ? ((ch_en != 4'h0) && ((hit & ch_en) == ch_en))
		: |(hit & ch_en);
	assign pass_end = cd_tick && (cd_samp_reg == detect_sample_length - 12'h001);

	// mode state machine
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
			state_reg <= acm_pkg::ST_START;
		else if (long_low)
			state_reg <= acm_pkg::ST_RESET;
		else
		begin
			unique case (state_reg)
				acm_pkg::ST_RESET:
					if (LINK.sync_n)
						state_reg <= acm_pkg::ST_START;
				acm_pkg::ST_START, acm_pkg::ST_WAKE, acm_pkg::ST_CONV:
					if (cmd_stby)
						state_reg <= acm_pkg::ST_STBY;
					else if (state_reg != acm_pkg::ST_CONV && mod_tick && tcnt_reg ==
						(state_reg == acm_pkg::ST_START ? `ACM_STARTUP_MOD : `ACM_WAKE_MOD)
						- 18'h00001)
						state_reg <= acm_pkg::ST_CONV;
				acm_pkg::ST_STBY:
					if (cmd_wake)
						state_reg <= acm_pkg::ST_WAKE;
					else if (short_pulse && cfg_reg[`ACM_F_DETECT_ENABLE])
						state_reg <= acm_pkg::ST_DETECT;
				acm_pkg::ST_DETECT:
					if (cmd_wake)
						state_reg <= acm_pkg::ST_WAKE;
					else if (met || !cfg_reg[`ACM_F_DETECT_ENABLE])
						state_reg <= acm_pkg::ST_STBY;
			endcase
		end
	end

	// conversion segment timing
	assign restart = (state_reg != acm_pkg::ST_CONV) || short_pulse || osr_change;
	assign seg_len = chop ? dly_len + osr_len + osr_len + osr_len +
		((first_reg && gc_left_reg == 2'h1) ? `ACM_FIRST_EXTRA : 18'h00000)
		: osr_len;
	assign seg_end = (state_reg == acm_pkg::ST_CONV) && !restart && mod_tick &&
		(tcnt_reg == seg_len - 18'h00001);
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || (state_reg == acm_pkg::ST_CONV && restart) || seg_end ||
			state_reg == acm_pkg::ST_STBY || state_reg == acm_pkg::ST_DETECT ||
			state_reg == acm_pkg::ST_RESET || long_low || (state_reg != acm_pkg::ST_CONV &&
			mod_tick && tcnt_reg == (state_reg == acm_pkg::ST_START ? `ACM_STARTUP_MOD
			: `ACM_WAKE_MOD) - 18'h00001))
			tcnt_reg <= 18'h00000;
		else if (mod_tick)
			tcnt_reg <= tcnt_reg + 18'h00001;
	end

	// chop bookkeeping: polarity, filter reset, segments before a result
	always_ff @(posedge MCLK_I)
	begin
		frst_reg <= 1'b0;
		if (SYS_RST_I || restart)
		begin
			pol_reg     <= 1'b0;
			first_reg   <= 1'b1;
			gc_left_reg <= chop ? 2'h2 : 2'h1;
		end
		else if (seg_end)
		begin
			if (chop)
			begin
				pol_reg  <= !pol_reg;
				frst_reg <= 1'b1;
			end
			if (gc_left_reg == 2'h1)
				first_reg <= 1'b0;
			else
				gc_left_reg <= gc_left_reg - 2'h1;
		end
	end

	// per-channel result, average and exceed counting
	for (genvar i = 0; i < 4; i++)
	begin : g_ch
		logic signed [23:0] s, p;
		logic        [24:0] sum;
		logic        [23:0] mag;
		logic        [7:0]  exc_reg;
		assign s      = SAMPLE_I[24*i+23:24*i];
		assign p      = prev_reg[24*i+23:24*i];
		assign sum    = 25'({s[23], s} + {p[23], p});
		assign mag    = s[23] ? 24'(-s) : s;
		assign hit[i] = exc_reg >= detect_exceed_count;
		always_ff @(posedge MCLK_I)
		begin
			if (seg_end)
			begin
				prev_reg[24*i+23:24*i] <= s;
				if (gc_left_reg == 2'h1)
					data_reg[24*i+23:24*i] <= chop ? sum[24:1] : s;
			end
		end
		always_ff @(posedge MCLK_I)
		begin
			if (SYS_RST_I || state_reg != acm_pkg::ST_DETECT || pass_end)
				exc_reg <= 8'h00;
			else if (cd_tick && mag > {thr_up_reg, thr_lo_reg[15:8]} && exc_reg != 8'hFF)
				exc_reg <= exc_reg + 8'h01;
		end
	end

	// detect sample counting, pass restarts if nothing met
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || state_reg != acm_pkg::ST_DETECT || pass_end)
			cd_samp_reg <= 12'h000;
		else if (cd_tick)
			cd_samp_reg <= cd_samp_reg + 12'h001;
	end

	// result strobe and active-low data ready
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || state_reg == acm_pkg::ST_RESET)
		begin
			valid_reg    <= 1'b0;
			data_ready_n_cnt_reg <= 4'h0;
		end
		else
		begin
			valid_reg <= seg_end && (gc_left_reg == 2'h1);
			if ((seg_end && gc_left_reg == 2'h1) || (state_reg == acm_pkg::ST_DETECT && met))
				data_ready_n_cnt_reg <= `ACM_DATA_READY_N_LOW_CYC;
			else if (data_ready_n_cnt_reg != 4'h0)
				data_ready_n_cnt_reg <= data_ready_n_cnt_reg - 4'h1;
		end
	end

	// outputs; detect results never reach the data port
	assign LINK.data_ready_n = (data_ready_n_cnt_reg == 4'h0);
	assign CONV_DATA_O       = data_reg;
	assign CONV_VALID_O      = valid_reg;
	assign POLARITY_O        = pol_reg;
	assign FILTER_RST_O      = frst_reg;
	assign PHASE_BYPASS_O    = chop;
	assign DC_TEST_OK_O      = !chop;
	assign POWER_LEVEL_O     = (clock_reg[`ACM_F_PWR_HI:`ACM_F_PWR_LO] == 2'h3) ? `ACM_PWR_HR
		: clock_reg[`ACM_F_PWR_HI:`ACM_F_PWR_LO];
	assign CHAN_ACTIVE_O     = (state_reg == acm_pkg::ST_CONV) ? ch_en : 4'h0;
	assign REF_PD_O          = (state_reg == acm_pkg::ST_STBY) ||
		(state_reg == acm_pkg::ST_DETECT);
	assign MODE_O            = state_reg;
endmodule

// file: rtl/acm_cfg.svh
// constants for the conversion mode control link and both of its ends
`ifndef ACM_CFG_SVH
`define ACM_CFG_SVH
`define ACM_OP_STANDBY     16'h0022
`define ACM_OP_WAKE        16'h0033
`define ACM_OP_WREG        16'h6000
`define ACM_RA_CLOCK       4'h0
`define ACM_RA_GCHOP       4'h1
`define ACM_RA_CFG         4'h2
`define ACM_RA_THR_UP      4'h3
`define ACM_RA_THR_LO      4'h4
`define ACM_CLOCK_RST      16'h0F0E
`define ACM_GCHOP_RST      16'h0003
`define ACM_CFG_RST        16'h0000
`define ACM_THR_RST        16'h0000
`define ACM_F_CHEN_HI      11
`define ACM_F_CHEN_LO      8
`define ACM_F_OSR_HI       4
`define ACM_F_OSR_LO       2
`define ACM_F_PWR_HI       1
`define ACM_F_PWR_LO       0
`define ACM_F_CHOP_ENABLE        8
`define ACM_F_CHOP_SETTLE_DELAY_HI    3
`define ACM_F_CHOP_SETTLE_DELAY_LO    0
`define ACM_F_DETECT_SAMPLE_LENGTH_HI    10
`define ACM_F_DETECT_SAMPLE_LENGTH_LO    8
`define ACM_F_DETECT_EXCEED_COUNT_HI    6
`define ACM_F_DETECT_EXCEED_COUNT_LO    4
`define ACM_F_DETECT_ALL_CHANNELS     3
`define ACM_F_DETECT_ENABLE        0
`define ACM_PWR_HR         2'h2
`define ACM_MOD_DIV        8'h04
`define ACM_STARTUP_MOD    18'h0012C
`define ACM_FIRST_EXTRA    18'h0002C
`define ACM_WAKE_MOD       18'h00008
`define ACM_RSL_CYC        16'h0040
`define ACM_SYNC_SHORT_CYC 16'h0008
`define ACM_DATA_READY_N_LOW_CYC   4'h4
`define ACM_CLK_HZ         50000000
`define ACM_CD_RATE_HZ     2700
`define ACM_CD_PERIOD_CYC  (`ACM_CLK_HZ / `ACM_CD_RATE_HZ)
`define ACM_H_CMD          5'h00
`define ACM_H_ARG          5'h04
`define ACM_H_SYNC         5'h08
`define ACM_H_CTRL         5'h0C
`define ACM_H_STAT         5'h10
`endif

// file: rtl/acm_pkg.sv
// types used by the converter end of the conversion mode control link and its checks
package acm_pkg;
	typedef enum logic [2:0] {ST_RESET, ST_START, ST_CONV, ST_STBY, ST_WAKE, ST_DETECT} acm_state_t;
endpackage

// file: rtl/acm_if.sv
// link between host controller and converter mode control
interface acm_if;
	logic        cmd_valid;
	logic [15:0] cmd_op;
	logic [3:0]  cmd_addr;
	logic [15:0] cmd_data;
	logic        sync_n;
	logic        external_clock_input_run;
	logic        data_ready_n;
	modport dev (input cmd_valid, cmd_op, cmd_addr, cmd_data, sync_n, external_clock_input_run,
		output data_ready_n);
	modport host (output cmd_valid, cmd_op, cmd_addr, cmd_data, sync_n, external_clock_input_run,
		input data_ready_n);
endinterface

// file: rtl/acm_lut.sv
// fixed decode tables for oversampling, chop delay and detect field codes
module acm_lut
(
	input  wire logic [2:0]  OSR_CODE_I,
	input  wire logic [3:0]  DLY_CODE_I,
	input  wire logic [2:0]  LEN_CODE_I,
	input  wire logic [2:0]  NUM_CODE_I,
	output logic      [17:0] OSR_LEN_O,
	output logic      [17:0] DLY_LEN_O,
	output logic      [11:0] DETECT_SAMPLE_LENGTH_O,
	output logic      [7:0]  DETECT_EXCEED_COUNT_O
);
	// oversampling ratio 128 doubling per code, delay 2 to 65536 modulator periods
	assign OSR_LEN_O = 18'h00080 << OSR_CODE_I;
	assign DLY_LEN_O = 18'h00002 << DLY_CODE_I;
	assign DETECT_EXCEED_COUNT_O  = 8'h01 << NUM_CODE_I;

	// sample length table, 128 up to 3584
	always_comb
	begin
		unique case (LEN_CODE_I)
			3'h0: DETECT_SAMPLE_LENGTH_O = 12'h080;
			3'h1: DETECT_SAMPLE_LENGTH_O = 12'h100;
			3'h2: DETECT_SAMPLE_LENGTH_O = 12'h200;
			3'h3: DETECT_SAMPLE_LENGTH_O = 12'h300;
			3'h4: DETECT_SAMPLE_LENGTH_O = 12'h400;
			3'h5: DETECT_SAMPLE_LENGTH_O = 12'h600;
			3'h6: DETECT_SAMPLE_LENGTH_O = 12'h800;
			3'h7: DETECT_SAMPLE_LENGTH_O = 12'hE00;
		endcase
	end
endmodule

// file: rtl/acm_host.sv
// host end: avalon registers to commands, sync pulses and clock control
`include "acm_cfg.svh"
module acm_host
(
	input  wire logic        MCLK_I,
	input  wire logic        SYS_RST_I,
	acm_if.host              LINK,
	input  wire logic [4:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O
);
	logic        ack_reg, cmd_valid_reg, clk_run_reg, stby_reg, detect_reg, seen_reg;
	logic        data_ready_n_d_reg;
	logic [15:0] cmd_op_reg, sync_cnt_reg, fall_cnt_reg;
	logic [19:0] arg_reg;
	logic [31:0] rdata_reg;
	logic        do_wr, data_ready_n_fall;

	// one wait cycle per access
	assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
	assign do_wr             = AVS_WRITE_I && ack_reg;
	assign data_ready_n_fall         = data_ready_n_d_reg && !LINK.data_ready_n;
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
			ack_reg <= 1'b0;
		else
			ack_reg <= (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
	end

	// read data captured in the wait cycle
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
			rdata_reg <= 32'h00000000;
		else if (AVS_READ_I && !ack_reg)
		begin
			unique case (AVS_ADDRESS_I)
				`ACM_H_CMD:  rdata_reg <= {16'h0000, cmd_op_reg};
				`ACM_H_ARG:  rdata_reg <= {12'h000, arg_reg};
				`ACM_H_CTRL: rdata_reg <= {31'h00000000, clk_run_reg};
				`ACM_H_STAT: rdata_reg <= {fall_cnt_reg, 11'h000, detect_reg, stby_reg,
					seen_reg, (sync_cnt_reg != 16'h0000), LINK.data_ready_n};
				default:     rdata_reg <= 32'h00000000;
			endcase
		end
	end

	// command launch, one cycle per write
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
		begin
			cmd_valid_reg <= 1'b0;
			cmd_op_reg    <= 16'h0000;
			arg_reg       <= 20'h00000;
		end
		else
		begin
			cmd_valid_reg <= do_wr && (AVS_ADDRESS_I == `ACM_H_CMD);
			if (do_wr && AVS_ADDRESS_I == `ACM_H_CMD)
				cmd_op_reg <= AVS_WRITEDATA_I[15:0];
			if (do_wr && AVS_ADDRESS_I == `ACM_H_ARG)
				arg_reg <= AVS_WRITEDATA_I[19:0];
		end
	end

	// sync pulse timer: short for sync or detect entry, long for reset
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
			sync_cnt_reg <= 16'h0000;
		else if (do_wr && AVS_ADDRESS_I == `ACM_H_SYNC && AVS_WRITEDATA_I[1])
			sync_cnt_reg <= 16'(`ACM_RSL_CYC + `ACM_RSL_CYC);
		else if (do_wr && AVS_ADDRESS_I == `ACM_H_SYNC && AVS_WRITEDATA_I[0])
			sync_cnt_reg <= `ACM_SYNC_SHORT_CYC;
		else if (sync_cnt_reg != 16'h0000)
			sync_cnt_reg <= sync_cnt_reg - 16'h0001;
	end

	// mode tracking and external clock control
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
		begin
			clk_run_reg <= 1'b1;
			stby_reg    <= 1'b0;
			detect_reg  <= 1'b0;
		end
		else if (do_wr && AVS_ADDRESS_I == `ACM_H_CTRL)
			clk_run_reg <= AVS_WRITEDATA_I[0];
		else if (cmd_valid_reg && cmd_op_reg == `ACM_OP_STANDBY)
			stby_reg <= 1'b1;
		else if ((cmd_valid_reg && cmd_op_reg == `ACM_OP_WAKE) ||
			(do_wr && AVS_ADDRESS_I == `ACM_H_SYNC && AVS_WRITEDATA_I[1]))
		begin
			clk_run_reg <= 1'b1;
			stby_reg    <= 1'b0;
			detect_reg  <= 1'b0;
		end
		else if (do_wr && AVS_ADDRESS_I == `ACM_H_SYNC && AVS_WRITEDATA_I[0] && stby_reg)
		begin
			clk_run_reg <= 1'b0;
			detect_reg  <= 1'b1;
		end
		else if (detect_reg && data_ready_n_fall)
			detect_reg <= 1'b0;
	end

	// data ready falling edges; sticky flag, set wins over clear
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
		begin
			data_ready_n_d_reg   <= 1'b1;
			seen_reg     <= 1'b0;
			fall_cnt_reg <= 16'h0000;
		end
		else
		begin
			data_ready_n_d_reg <= LINK.data_ready_n;
			if (data_ready_n_fall)
			begin
				seen_reg     <= 1'b1;
				fall_cnt_reg <= fall_cnt_reg + 16'h0001;
			end
			else if (do_wr && AVS_ADDRESS_I == `ACM_H_STAT && AVS_WRITEDATA_I[2])
				seen_reg <= 1'b0;
		end
	end

	assign LINK.cmd_valid  = cmd_valid_reg;
	assign LINK.cmd_op     = cmd_op_reg;
	assign LINK.cmd_addr   = arg_reg[19:16];
	assign LINK.cmd_data   = arg_reg[15:0];
	assign LINK.sync_n     = (sync_cnt_reg == 16'h0000);
	assign LINK.external_clock_input_run  = clk_run_reg;
	assign AVS_READDATA_O  = rdata_reg;
endmodule

// file: testbench/acm_assertions.sv
// concurrent checks on the link and the converter state
module acm_assertions
(
	input wire logic        MCLK_I,
	input wire logic        SYS_RST_I,
	input wire logic        cmd_valid,
	input wire logic [15:0] cmd_op,
	input wire logic        sync_n,
	input wire logic        data_ready_n,
	input wire logic [2:0]  MODE_O,
	input wire logic        CONV_VALID_O,
	input wire logic        POLARITY_O,
	input wire logic        FILTER_RST_O,
	input wire logic        PHASE_BYPASS_O,
	input wire logic        DC_TEST_OK_O,
	input wire logic [3:0]  CHAN_ACTIVE_O,
	input wire logic        REF_PD_O
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] low_cnt_reg;
	logic [5:0] wake_cnt_reg;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);
	// saturating count of cycles with sync held low
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || sync_n)
			low_cnt_reg <= 8'h00;
		else if (low_cnt_reg != 8'hFF)
			low_cnt_reg <= low_cnt_reg + 8'h01;
	end
	// cycles spent in the wake state
	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I || MODE_O != acm_pkg::ST_WAKE)
			wake_cnt_reg <= 6'h00;
		else if (wake_cnt_reg != 6'h3F)
			wake_cnt_reg <= wake_cnt_reg + 6'h01;
	end
	a_data_ready_n_four_low: assert property ($fell(data_ready_n) |->
		(!data_ready_n) [*4] ##1 data_ready_n) else $error("data ready pulse width");
	a_valid_with_data_ready_n: assert property (CONV_VALID_O |-> $fell(data_ready_n))
		else $error("result without data ready edge");
	a_swap_filter_rst: assert property (FILTER_RST_O |-> $changed(POLARITY_O))
		else $error("filter reset without polarity swap");
	a_chop_no_phase: assert property (PHASE_BYPASS_O != DC_TEST_OK_O)
		else $error("phase bypass and dc test disagree");
	a_standby_cmd: assert property (cmd_valid && cmd_op == 16'h0022 &&
		MODE_O == acm_pkg::ST_CONV |=> MODE_O == acm_pkg::ST_STBY) else $error("no standby");
	a_standby_quiet: assert property ((MODE_O == acm_pkg::ST_STBY) [*2] |->
		CHAN_ACTIVE_O == 4'h0 && REF_PD_O) else $error("standby not powered down");
	a_resume_cmd: assert property (cmd_valid && cmd_op == 16'h0033 &&
		MODE_O == acm_pkg::ST_STBY |=> MODE_O == acm_pkg::ST_WAKE) else $error("no wake");
	a_wake_eight: assert property (MODE_O == acm_pkg::ST_WAKE ##1
		MODE_O == acm_pkg::ST_CONV |-> wake_cnt_reg >= 6'h1C && wake_cnt_reg <= 6'h22)
		else $error("wake length");
	a_detect_entry: assert property ($rose(MODE_O == acm_pkg::ST_DETECT) |->
		$past(MODE_O) == acm_pkg::ST_STBY) else $error("detect entered off standby");
	a_detect_exit: assert property (MODE_O == acm_pkg::ST_DETECT ##1
		MODE_O != acm_pkg::ST_DETECT |-> MODE_O == acm_pkg::ST_STBY) else $error("detect exit");
	a_detect_hidden: assert property (MODE_O == acm_pkg::ST_DETECT |-> !CONV_VALID_O)
		else $error("result shown in detect");
	a_long_low_reset: assert property (low_cnt_reg >= 8'h46 |->
		MODE_O == acm_pkg::ST_RESET) else $error("long sync low without reset");
	c_chop_result: cover property (CONV_VALID_O && PHASE_BYPASS_O);
	c_detect_hit: cover property (MODE_O == acm_pkg::ST_DETECT && !data_ready_n);
	c_wake_done: cover property (MODE_O == acm_pkg::ST_WAKE ##1 MODE_O == acm_pkg::ST_CONV);
endmodule

// file: testbench/test_adc_conversion_mode_control.sv
// bench joining host and converter ends over the link
`include "acm_cfg.svh"
module test_adc_conversion_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CDP = 20;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  av_addr = 5'h00;
	logic        av_rd = 1'b0;
	logic        av_wr = 1'b0;
	logic [31:0] av_wdata = 32'h0;
	logic [31:0] av_rdata;
	logic        av_wait;
	logic [95:0] smp = {24'h000000, 24'h012345, 24'hFEDCBA, 24'h012346};
	logic [95:0] conv_data;
	logic        conv_valid;
	logic        pol;
	logic        frst;
	logic        pbyp;
	logic        dcok;
	logic [1:0]  power_level_select;
	logic [3:0]  chact;
	logic        refpd;
	logic [2:0]  mode;
	logic [31:0] rd;
	int          bad_count = 0;
	int          check_count = 0;
	int          n;
	acm_if link ();
	acm_host i_acm_host (.MCLK_I(mclk), .SYS_RST_I(rst), .LINK(link.host),
		.AVS_ADDRESS_I(av_addr), .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr),
		.AVS_WRITEDATA_I(av_wdata), .AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait));
	acm_device #(.CD_PERIOD_CYC(CDP)) i_acm_device (.MCLK_I(mclk), .SYS_RST_I(rst),
		.LINK(link.dev), .SAMPLE_I(smp), .CONV_DATA_O(conv_data), .CONV_VALID_O(conv_valid),
		.POLARITY_O(pol), .FILTER_RST_O(frst), .PHASE_BYPASS_O(pbyp), .DC_TEST_OK_O(dcok),
		.POWER_LEVEL_O(power_level_select), .CHAN_ACTIVE_O(chact), .REF_PD_O(refpd), .MODE_O(mode));
	acm_assertions i_acm_assertions (.MCLK_I(mclk), .SYS_RST_I(rst),
		.cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .sync_n(link.sync_n),
		.data_ready_n(link.data_ready_n), .MODE_O(mode), .CONV_VALID_O(conv_valid),
		.POLARITY_O(pol), .FILTER_RST_O(frst), .PHASE_BYPASS_O(pbyp), .DC_TEST_OK_O(dcok),
		.CHAN_ACTIVE_O(chact), .REF_PD_O(refpd));
	// 50 MHz clock
	always #10 mclk = ~mclk;
	task report_and_stop;
	begin
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	end
	endtask
	task hang;
	begin
		chk(32'h0, 32'h1);
		report_and_stop;
	end
	endtask
	task idle(input int k);
		repeat (k) @(posedge mclk);
	endtask
	// one avalon access, held until waitrequest is seen low
	task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
	begin
		@(posedge mclk);
		av_addr <= a;
		av_wdata <= d;
		av_wr <= wr;
		av_rd <= !wr;
		@(posedge mclk);
		for (i = 0; i < 20 && av_wait !== 1'b0; i++)
			@(posedge mclk);
		if (av_wait !== 1'b0)
			hang;
		rd = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	end
	endtask
	task cmd(input logic [15:0] op);
	begin
		av(1'b1, `ACM_H_CMD, {16'h0000, op});
		idle(3);
	end
	endtask
	task regwr(input logic [3:0] ra, input logic [15:0] v);
	begin
		av(1'b1, `ACM_H_ARG, {12'h000, ra, v});
		cmd(`ACM_OP_WREG);
	end
	endtask
	task wait_mode(input logic [2:0] m, input int lim);
		int i;
	begin
		for (i = 0; i < lim && mode !== m; i++)
			@(negedge mclk);
		if (mode !== m)
			hang;
	end
	endtask
	// n counts cycles up to the next data ready fall
	task wait_fall(input int lim, input bit must);
		logic p;
	begin
		p = link.data_ready_n;
		for (n = 0; n < lim && !(p === 1'b1 && link.data_ready_n === 1'b0); n++)
		begin
			p = link.data_ready_n;
			@(negedge mclk);
		end
		if (must && n >= lim)
			hang;
	end
	endtask
	task sync_pulse;
		int i;
	begin
		av(1'b1, `ACM_H_SYNC, 32'h1);
		for (i = 0; i < 50 && link.sync_n !== 1'b0; i++)
			@(negedge mclk);
		for (i = 0; i < 50 && link.sync_n !== 1'b1; i++)
			@(negedge mclk);
		if (link.sync_n !== 1'b1)
			hang;
	end
	endtask
	task t_cont;
		int p;
	begin
		wait_mode(acm_pkg::ST_CONV, 3000);
		for (p = 0; p < 4; p++)
		begin
			regwr(`ACM_RA_CLOCK, 16'h0F00 | 16'(p));
			chk(32'(power_level_select), (p == 3) ? 32'h2 : 32'(p)); // power level
		end
		wait_fall(5000, 1'b1);
		wait_fall(1000, 1'b1);
		chk(32'(n), 32'h200); // result rate
		chk({8'h00, conv_data[23:0]}, 32'h012346); // result value
		$display("continuous test done");
	end
	endtask
	task t_chop;
		int c;
		int e;
	begin
		for (c = 0; c < 4; c++)
		begin
			regwr(`ACM_RA_GCHOP, 16'h0100 | 16'(c));
			sync_pulse;
			e = (2 * ((2 << c) + 384) + 44) * 4;
			wait_fall(20000, 1'b1);
			chk(32'(n >= e - 4 && n <= e + 8), 32'h1); // first result
			@(posedge mclk);
			smp[23:0] <= 24'h012348;
			wait_fall(5000, 1'b1);
			chk(32'(n), 32'(((2 << c) + 384) * 4)); // period
			chk({8'h00, conv_data[23:0]}, 32'h012347); // pair average
			@(posedge mclk);
			smp[23:0] <= 24'h012346;
		end
		chk({30'h0, pbyp, dcok}, 32'h2); // chop flags
		regwr(`ACM_RA_CLOCK, 16'h0F06);
		e = (2 * (16 + 768) + 44) * 4;
		wait_fall(20000, 1'b1);
		chk(32'(n >= e - 12 && n <= e + 4), 32'h1); // ratio restart
		regwr(`ACM_RA_GCHOP, 16'h0003);
		chk({30'h0, pbyp, dcok}, 32'h1); // flags off
		$display("chop test done");
	end
	endtask
	task t_stby;
	begin
		regwr(`ACM_RA_CLOCK, 16'h0502);
		cmd(`ACM_OP_STANDBY);
		wait_mode(acm_pkg::ST_STBY, 10);
		chk({27'h0, refpd, chact}, 32'h10); // powered down
		av(1'b0, `ACM_H_STAT, 32'h0);
		chk(rd & 32'h8, 32'h8); // standby status
		cmd(`ACM_OP_WAKE);
		wait_mode(acm_pkg::ST_CONV, 100);
		chk(32'(chact), 32'h5); // settings kept
		cmd(`ACM_OP_WAKE);
		chk(32'(mode), 32'h2); // resume ignored
		$display("standby test done");
	end
	endtask
	task t_detect;
	begin
		regwr(`ACM_RA_CLOCK, 16'h0302);
		regwr(`ACM_RA_THR_UP, 16'h0123);
		regwr(`ACM_RA_THR_LO, 16'h4500);
		regwr(`ACM_RA_CFG, 16'h0019);
		sync_pulse;
		chk(32'(mode), 32'h2); // entry refused
		cmd(`ACM_OP_STANDBY);
		sync_pulse;
		wait_mode(acm_pkg::ST_DETECT, 10);
		chk({31'h0, link.external_clock_input_run}, 32'h0); // clock stopped
		wait_fall(10 * CDP, 1'b1);
		chk(32'(n > CDP && n <= 3 * CDP + 4), 32'h1); // two hits
		wait_mode(acm_pkg::ST_STBY, 10);
		regwr(`ACM_RA_CLOCK, 16'h0502);
		sync_pulse;
		wait_fall(128 * CDP + 100, 1'b0);
		chk(32'(n), 32'(128 * CDP + 100)); // all channels
		chk(32'(mode), 32'h5); // still detecting
		av(1'b1, `ACM_H_STAT, 32'h4);
		regwr(`ACM_RA_CFG, 16'h0011);
		wait_mode(acm_pkg::ST_STBY, 300 * CDP);
		av(1'b0, `ACM_H_STAT, 32'h0);
		chk(rd & 32'h4, 32'h4); // any channel
		cmd(`ACM_OP_WAKE);
		wait_mode(acm_pkg::ST_CONV, 200);
		$display("detect test done");
	end
	endtask
	task t_reset;
	begin
		av(1'b1, `ACM_H_SYNC, 32'h2);
		wait_mode(acm_pkg::ST_RESET, 150);
		wait_mode(acm_pkg::ST_CONV, 3000);
		chk({26'h0, power_level_select, chact}, 32'h2F); // defaults back
		av(1'b0, 5'h14, 32'h0);
		chk(rd, 32'h0); // unmapped read
		$display("reset test done");
	end
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_cont;
		t_chop;
		t_stby;
		t_detect;
		t_reset;
		report_and_stop;
	end
endmodule
